// ===== logic/sdm_ctl.sv
module sdm_ctl #(
  parameter int PWR_WAIT_CYC = sdm_pkg::PWR_WAIT_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Link to memory
  sdm_link_if.ctl link
);

  typedef enum logic [2:0] {
    ST_POWER = 3'b000,
    ST_PRE = 3'b001,
    ST_REF1 = 3'b010,
    ST_REF2 = 3'b011,
    ST_MODE = 3'b100,
    ST_READY = 3'b101
  } sdm_state_t;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sdm_state_t state, next_state;
  logic [11:0] tmr, next_tmr;
  logic [3:0] cmd, next_cmd;
  logic [12:0] addr, next_addr;
  logic [12:0] mode_val, next_mode_val;
  logic [7:0] column, next_column;
  logic [31:0] wrdata, next_wrdata;
  logic [31:0] rddata, next_rddata;
  logic [3:0] pend, next_pend;
  logic [3:0] done;
  logic [2:0] rdcnt, next_rdcnt;
  logic [7:0] wrhold, next_wrhold;
  logic dq_oe_n, next_dq_oe_n;
  logic [31:0] next_hrdata;
  logic ap_vld, next_ap_vld;
  logic ap_wr, next_ap_wr;
  logic [7:0] ap_addr, next_ap_addr;
  logic [7:0] beats;
  logic [31:0] status;

  // ----------------------------------------------------------------
  // Bus slave, zero wait states
  // ----------------------------------------------------------------
  // Read data is taken in the address phase, so a read right after a
  // write to the same word returns the old value.
  always_comb begin
    status = {29'h0, !dq_oe_n, (rdcnt != 3'h0), (state == ST_READY)};
    next_ap_vld = hsel && htrans[1] && hready;
    next_ap_wr = hwrite;
    next_ap_addr = haddr[7:0];
    next_hrdata = hrdata;
    if (next_ap_vld && !hwrite) begin
      if (haddr[7:0] == sdm_pkg::OFF_MODE) begin
        next_hrdata = {19'h0, mode_val};
      end else if (haddr[7:0] == sdm_pkg::OFF_STATUS) begin
        next_hrdata = status;
      end else if (haddr[7:0] == sdm_pkg::OFF_RDDATA) begin
        next_hrdata = rddata;
      end else if (haddr[7:0] == sdm_pkg::OFF_WRDATA) begin
        next_hrdata = wrdata;
      end else if (haddr[7:0] == sdm_pkg::OFF_COLUMN) begin
        next_hrdata = {24'h0, column};
      end else begin
        next_hrdata = 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    beats = (mode_val[sdm_pkg::BL_LSB +: sdm_pkg::BL_W] == sdm_pkg::BL_2)
            ? 8'h01 :
            (mode_val[sdm_pkg::BL_LSB +: sdm_pkg::BL_W] == sdm_pkg::BL_4)
            ? 8'h03 :
            (mode_val[sdm_pkg::BL_LSB +: sdm_pkg::BL_W] == sdm_pkg::BL_8)
            ? 8'h07 :
            (mode_val[sdm_pkg::BL_LSB +: sdm_pkg::BL_W] == sdm_pkg::BL_PAGE)
            ? 8'hff : 8'h00;
    if (mode_val[sdm_pkg::WSINGLE_BIT]) begin
      beats = 8'h00;
    end
    next_state = state;
    next_tmr = (tmr != 12'h000) ? tmr - 12'h001 : tmr;
    next_cmd = sdm_pkg::CMD_NOP;
    next_addr = addr;
    next_rdcnt = (rdcnt != 3'h0) ? rdcnt - 3'h1 : rdcnt;
    next_rddata = (rdcnt == 3'h1) ? link.dq : rddata;
    next_wrhold = (wrhold != 8'h00) ? wrhold - 8'h01 : wrhold;
    next_dq_oe_n = (wrhold == 8'h00) ? 1'b1 : dq_oe_n;
    done = 4'h0;
    case (state)
      ST_POWER: begin
        if (tmr == 12'h000) begin
          next_cmd = sdm_pkg::CMD_PRECHARGE;
          next_addr = 13'h0000;
          next_addr[sdm_pkg::PRE_ALL_BIT] = 1'b1;
          next_tmr = 12'(sdm_pkg::PRE_WAIT_CYC);
          next_state = ST_PRE;
        end
      end
      ST_PRE, ST_REF1: begin
        if (tmr == 12'h000) begin
          next_cmd = sdm_pkg::CMD_REFRESH;
          next_tmr = 12'(sdm_pkg::REF_WAIT_CYC);
          next_state = (state == ST_PRE) ? ST_REF1 : ST_REF2;
        end
      end
      ST_REF2: begin
        if (tmr == 12'h000) begin
          next_cmd = sdm_pkg::CMD_LOAD_MODE;
          next_addr = mode_val;
          next_tmr = 12'(sdm_pkg::MODE_WAIT_CYC);
          next_state = ST_MODE;
        end
      end
      ST_MODE: begin
        if (tmr == 12'h000) begin
          next_state = ST_READY;
        end
      end
      default: begin
        if (pend[sdm_pkg::REQ_STOP]) begin
          next_cmd = sdm_pkg::CMD_STOP;
          next_wrhold = 8'h00;
          next_dq_oe_n = 1'b1;
          done[sdm_pkg::REQ_STOP] = 1'b1;
        end else if (rdcnt != 3'h0 || !dq_oe_n) begin
          next_cmd = sdm_pkg::CMD_NOP;
        end else if (pend[sdm_pkg::REQ_RELOAD]) begin
          next_cmd = sdm_pkg::CMD_LOAD_MODE;
          next_addr = mode_val;
          next_tmr = 12'(sdm_pkg::MODE_WAIT_CYC);
          next_state = ST_MODE;
          done[sdm_pkg::REQ_RELOAD] = 1'b1;
        end else if (pend[sdm_pkg::REQ_READ]) begin
          next_cmd = sdm_pkg::CMD_READ;
          next_addr = {5'h00, column};
          next_rdcnt = (mode_val[sdm_pkg::LAT_LSB +: sdm_pkg::LAT_W]
                        == sdm_pkg::LAT_2) ? 3'h3 : 3'h4;
          done[sdm_pkg::REQ_READ] = 1'b1;
        end else if (pend[sdm_pkg::REQ_WRITE]) begin
          next_cmd = sdm_pkg::CMD_WRITE;
          next_addr = {5'h00, column};
          next_wrhold = beats;
          next_dq_oe_n = 1'b0;
          done[sdm_pkg::REQ_WRITE] = 1'b1;
        end
      end
    endcase
    next_mode_val = mode_val;
    next_column = column;
    next_wrdata = wrdata;
    next_pend = pend & ~done;
    if (ap_vld && ap_wr) begin
      if (ap_addr == sdm_pkg::OFF_MODE) begin
        next_mode_val = hwdata[12:0];
      end else if (ap_addr == sdm_pkg::OFF_CTRL) begin
        next_pend = next_pend | hwdata[3:0]; // New request wins
      end else if (ap_addr == sdm_pkg::OFF_WRDATA) begin
        next_wrdata = hwdata;
      end else if (ap_addr == sdm_pkg::OFF_COLUMN) begin
        next_column = hwdata[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_POWER;
      tmr <= 12'(PWR_WAIT_CYC - 1);
      cmd <= sdm_pkg::CMD_NOP;
      addr <= 13'h0000;
      mode_val <= sdm_pkg::MODE_RESET;
      column <= 8'h00;
      wrdata <= 32'h0000_0000;
      rddata <= 32'h0000_0000;
      pend <= 4'h0;
      rdcnt <= 3'h0;
      wrhold <= 8'h00;
      dq_oe_n <= 1'b1;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      ap_vld <= 1'b0;
      ap_wr <= 1'b0;
      ap_addr <= 8'h00;
    end else begin
      state <= next_state;
      tmr <= next_tmr;
      cmd <= next_cmd;
      addr <= next_addr;
      mode_val <= next_mode_val;
      column <= next_column;
      wrdata <= next_wrdata;
      rddata <= next_rddata;
      pend <= next_pend;
      rdcnt <= next_rdcnt;
      wrhold <= next_wrhold;
      dq_oe_n <= next_dq_oe_n;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ap_vld <= next_ap_vld;
      ap_wr <= next_ap_wr;
      ap_addr <= next_ap_addr;
    end
  end

  assign link.cmd = cmd;
  assign link.addr = addr;
  assign link.ba = 2'b00;
  assign link.dq_ctl_out = wrdata;
  assign link.dq_ctl_oe_n = dq_oe_n;

endmodule : sdm_ctl

// ===== logic/sdm_dev.sv
module sdm_dev (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link to controller
  sdm_link_if.dev link,
  // Memory core side
  output logic [7:0] core_col,
  output logic core_rd,
  output logic core_wr,
  output logic [31:0] core_wr_data,
  input wire logic [31:0] core_rd_data,
  // Mode state
  output logic [12:0] mode,
  output logic mode_valid
);

  // ----------------------------------------------------------------
  // Burst helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] span_mask(input logic [2:0] code);
    logic [7:0] m;
    m = 8'h00;
    case (code)
      sdm_pkg::BL_2: m = 8'h01;
      sdm_pkg::BL_4: m = 8'h03;
      sdm_pkg::BL_8: m = 8'h07;
      sdm_pkg::BL_PAGE: m = 8'hff;
      default: m = 8'h00; // Reserved lengths act as one beat
    endcase
    return m;
  endfunction : span_mask

  function automatic logic [7:0] beat_col(input logic [7:0] start,
                                          input logic [7:0] cnt,
                                          input logic [7:0] m,
                                          input logic seq);
    logic [7:0] off;
    off = seq ? (start + cnt) : (start ^ cnt);
    return (start & ~m) | (off & m);
  endfunction : beat_col

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] start_col;
  logic [7:0] next_start_col;
  logic [7:0] beat_cnt;
  logic [7:0] next_beat_cnt;
  logic [7:0] mask;
  logic [7:0] next_mask;
  logic seq;
  logic next_seq;
  logic burst_on;
  logic next_burst_on;
  logic burst_wr;
  logic next_burst_wr;
  logic [7:0] next_core_col;
  logic next_core_rd;
  logic next_core_wr;
  logic [31:0] next_core_wr_data;
  logic [12:0] next_mode;
  logic next_mode_valid;
  logic [31:0] stage_data;
  logic [31:0] next_stage_data;
  logic stage_vld;
  logic next_stage_vld;
  logic [31:0] dq_out;
  logic [31:0] next_dq_out;
  logic dq_oe_n;
  logic next_dq_oe_n;

  logic cmd_sel;
  logic is_rd;
  logic is_wr;
  logic is_stop;
  logic is_load;
  logic normal_op;
  logic lat_two;
  logic [7:0] cmd_mask;
  logic cmd_seq;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  always_comb begin
    cmd_sel = !link.cmd[3];
    is_rd = cmd_sel && (link.cmd == sdm_pkg::CMD_READ);
    is_wr = cmd_sel && (link.cmd == sdm_pkg::CMD_WRITE);
    is_stop = cmd_sel && (link.cmd == sdm_pkg::CMD_STOP);
    is_load = cmd_sel && (link.cmd == sdm_pkg::CMD_LOAD_MODE);
    normal_op = (mode[sdm_pkg::OPM_LSB +: sdm_pkg::OPM_W]
                 == sdm_pkg::OPM_NORMAL);
    lat_two = (mode[sdm_pkg::LAT_LSB +: sdm_pkg::LAT_W]
               == sdm_pkg::LAT_2);
    cmd_mask = span_mask(mode[sdm_pkg::BL_LSB +: sdm_pkg::BL_W]);
    if (is_wr && mode[sdm_pkg::WSINGLE_BIT]) begin
      cmd_mask = 8'h00;
    end
    // Interleaved full page is not offered, so it runs sequential
    cmd_seq = !mode[sdm_pkg::ORDER_BIT] || (cmd_mask == 8'hff);
  end

  // ----------------------------------------------------------------
  // Mode register and burst sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_mode = mode;
    next_mode_valid = mode_valid;
    next_start_col = start_col;
    next_beat_cnt = beat_cnt;
    next_mask = mask;
    next_seq = seq;
    next_burst_on = burst_on;
    next_burst_wr = burst_wr;
    next_core_col = core_col;
    next_core_rd = 1'b0;
    next_core_wr = 1'b0;
    next_core_wr_data = core_wr_data;
    if (is_load) begin
      next_mode = link.addr[sdm_pkg::MODE_W-1:0];
      next_mode_valid = 1'b1;
      next_burst_on = 1'b0;
    end else if ((is_rd || is_wr) && mode_valid
                 && normal_op) begin
      // A new command cuts any running burst short
      next_start_col = link.addr[sdm_pkg::COL_W-1:0];
      next_core_col = link.addr[sdm_pkg::COL_W-1:0];
      next_core_rd = is_rd;
      next_core_wr = is_wr;
      next_core_wr_data = link.dq;
      next_beat_cnt = 8'h01;
      next_mask = cmd_mask;
      next_seq = cmd_seq;
      next_burst_on = (cmd_mask != 8'h00);
      next_burst_wr = is_wr;
    end else if (is_stop) begin
      next_burst_on = 1'b0;
    end else if (burst_on) begin
      next_core_col = beat_col(start_col, beat_cnt, mask, seq);
      next_core_rd = !burst_wr;
      next_core_wr = burst_wr;
      next_core_wr_data = link.dq;
      next_beat_cnt = beat_cnt + 8'h01;
      if ((beat_cnt == mask) && (mask != 8'hff)) begin
        next_burst_on = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= sdm_pkg::MODE_RESET;
      mode_valid <= 1'b0;
      start_col <= 8'h00;
      beat_cnt <= 8'h00;
      mask <= 8'h00;
      seq <= 1'b1;
      burst_on <= 1'b0;
      burst_wr <= 1'b0;
      core_col <= 8'h00;
      core_rd <= 1'b0;
      core_wr <= 1'b0;
      core_wr_data <= 32'h0000_0000;
    end else begin
      mode <= next_mode;
      mode_valid <= next_mode_valid;
      start_col <= next_start_col;
      beat_cnt <= next_beat_cnt;
      mask <= next_mask;
      seq <= next_seq;
      burst_on <= next_burst_on;
      burst_wr <= next_burst_wr;
      core_col <= next_core_col;
      core_rd <= next_core_rd;
      core_wr <= next_core_wr;
      core_wr_data <= next_core_wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Read data pipeline
  // ----------------------------------------------------------------
  // Core answers during the cycle after the command edge, so the
  // shortest latency needs no extra stage.
  always_comb begin
    next_stage_data = core_rd_data;
    next_stage_vld = core_rd;
    if (lat_two) begin
      next_dq_out = core_rd_data;
      next_dq_oe_n = !core_rd;
    end else begin
      next_dq_out = stage_data;
      next_dq_oe_n = !stage_vld;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage_data <= 32'h0000_0000;
      stage_vld <= 1'b0;
      dq_out <= 32'h0000_0000;
      dq_oe_n <= 1'b1;
    end else begin
      stage_data <= next_stage_data;
      stage_vld <= next_stage_vld;
      dq_out <= next_dq_out;
      dq_oe_n <= next_dq_oe_n;
    end
  end

  assign link.dq_dev_out = dq_out;
  assign link.dq_dev_oe_n = dq_oe_n;

endmodule : sdm_dev

// ===== logic/sdm_link_if.sv
interface sdm_link_if;
  // Command and address
  logic [3:0] cmd;
  logic [12:0] addr;
  logic [1:0] ba;
  // Data pins, one driver set per end
  logic [31:0] dq_ctl_out;
  logic dq_ctl_oe_n;
  logic [31:0] dq_dev_out;
  logic dq_dev_oe_n;
  logic [31:0] dq;

  // Undriven bus reads as zero
  assign dq = !dq_dev_oe_n ? dq_dev_out :
              !dq_ctl_oe_n ? dq_ctl_out : 32'h0000_0000;

  modport dev (input cmd, addr, ba, dq, output dq_dev_out, dq_dev_oe_n);
  modport ctl (output cmd, addr, ba, dq_ctl_out, dq_ctl_oe_n, input dq);
endinterface : sdm_link_if

// ===== logic/sdm_pkg.sv
// Summary of operation
// - Controller waits 100 us before real commands
// - Only inhibit or no-operation during power-up wait
// - Precharge all banks after the wait
// - Two auto refreshes before mode programming
// - Load mode before any operational command
// - Mode value held until next load
// - Mode register field layout
// - Load mode only when idle, then wait
// - Lengths 1,2,4,8; full page sequential only
// - Burst length caps columns per command
// - Full page runs until burst terminate
// - Upper column bits select wrapping burst block
// - Low column bits give first location
// - Full page wraps to start of page
// - Order select bit picks sequential or interleaved
// - Sequential adds, interleaved XORs the count
// - Controller never programs reserved encodings; sdm_ctl loads mode_val as written, unchecked
// - Read latency two or three clocks
// - Normal mode only with both mode bits zero
// - Write single select makes writes one location
package sdm_pkg;

  // ----------------------------------------------------------------
  // Link widths and commands {cs_n, ras_n, cas_n, we_n}
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int BA_W = 2;
  localparam int DQ_W = 32;
  localparam int COL_W = 8;
  localparam int PRE_ALL_BIT = 10;

  typedef enum logic [3:0] {
    CMD_INHIBIT = 4'b1111,
    CMD_NOP = 4'b0111,
    CMD_ACTIVE = 4'b0011,
    CMD_READ = 4'b0101,
    CMD_WRITE = 4'b0100,
    CMD_STOP = 4'b0110,
    CMD_PRECHARGE = 4'b0010,
    CMD_REFRESH = 4'b0001,
    CMD_LOAD_MODE = 4'b0000
  } sdm_cmd_t;

  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int MODE_W = 13;
  localparam int BL_LSB = 0;
  localparam int BL_W = 3;
  localparam int ORDER_BIT = 3;
  localparam int LAT_LSB = 4;
  localparam int LAT_W = 3;
  localparam int OPM_LSB = 7;
  localparam int OPM_W = 2;
  localparam int WSINGLE_BIT = 9;
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] LAT_2 = 3'h2;
  localparam logic [2:0] LAT_3 = 3'h3;
  localparam logic [1:0] OPM_NORMAL = 2'h0;
  localparam logic [12:0] MODE_RESET = 13'h0022;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int PWR_WAIT_NS = 100000;
  localparam int PWR_WAIT_CYC = (PWR_WAIT_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam int PRE_WAIT_NS = 20;
  localparam int PRE_WAIT_CYC = (PRE_WAIT_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam int REF_WAIT_NS = 70;
  localparam int REF_WAIT_CYC = (REF_WAIT_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam int MODE_WAIT_CYC = 2;
  localparam int TMR_W = 12;

  // ----------------------------------------------------------------
  // Controller register offsets and bits
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_RDDATA = 8'h0c;
  localparam logic [7:0] OFF_WRDATA = 8'h10;
  localparam logic [7:0] OFF_COLUMN = 8'h14;
  localparam int REQ_READ = 0;
  localparam int REQ_WRITE = 1;
  localparam int REQ_STOP = 2;
  localparam int REQ_RELOAD = 3;

endpackage : sdm_pkg

// ===== test/sdm_init_mode_burst_bench.sv
module sdram_init_mode_burst_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PW = 20;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, core_rd, core_wr, mode_valid;
  logic [7:0] core_col;
  logic [31:0] core_wr_data, core_rd_data;
  logic [12:0] mode;
  int bad_count = 0;
  int n_checks = 0;
  int seed;
  logic [7:0] rq[$];
  logic [7:0] wq[$];
  logic [31:0] wd[$];

  sdm_link_if u_sdm_link_if();
  sdm_ctl #(.PWR_WAIT_CYC(PW)) u_sdm_ctl (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link(u_sdm_link_if));
  sdm_dev u_sdm_dev (.hclk(hclk), .hresetn(hresetn), .link(u_sdm_link_if),
    .core_col(core_col), .core_rd(core_rd), .core_wr(core_wr),
    .core_wr_data(core_wr_data), .core_rd_data(core_rd_data),
    .mode(mode), .mode_valid(mode_valid));
  sdm_link_chk #(.PWR_WAIT_CYC(PW)) u_sdm_link_chk (.hclk(hclk),
    .hresetn(hresetn), .cmd(u_sdm_link_if.cmd),
    .addr(u_sdm_link_if.addr),
    .dq_ctl_oe_n(u_sdm_link_if.dq_ctl_oe_n),
    .dq_dev_oe_n(u_sdm_link_if.dq_dev_oe_n));

  // ----------------------------------------------------------------
  // Memory core stand-in and beat monitor
  // ----------------------------------------------------------------
  assign core_rd_data = {24'hc35a96, core_col};
  initial begin
    forever #12.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (core_rd === 1'b1) rq.push_back(core_col);
    if (core_wr === 1'b1) begin
      wq.push_back(core_col);
      wd.push_back(core_wr_data);
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  task chk(input bit ok, input string what);
    n_checks++;
    if (!ok) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : chk

  task hang(input int k);
    if (k > 100) begin
      bad_count++;
      conclude();
    end
  endtask : hang

  task rdy;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      hang(k);
      @(posedge hclk);
    end
  endtask : rdy

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    r = hrdata;
  endtask : ahb

  task poll(input int b, input logic v);
    int k;
    logic [31:0] r;
    k = 0;
    do begin
      ahb(1'b0, sdm_pkg::OFF_STATUS, 32'h0, r);
      k++;
      hang(k);
    end while (r[b] !== v);
  endtask : poll

  task wait_n(input bit w, input int n);
    int k;
    k = 0;
    while ((w ? wq.size() : rq.size()) < n) begin
      k++;
      hang(k);
      @(posedge hclk);
    end
  endtask : wait_n

  function int ecol(int s, int i, int b, int o);
    int n;
    n = 1 << b;
    if (b == 7) return (s + i) % 256;
    return (s & ~(n - 1)) | ((o != 0 ? (s ^ i) : (s + i)) & (n - 1));
  endfunction : ecol

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    conclude();
  end

  initial begin
    int i, j, k, n, b, o, cl;
    logic ws;
    logic [12:0] m;
    logic [7:0] s, pg;
    logic [31:0] r, d;
    seed = 32'hdc4e;
    pg = 8'hfd;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, sdm_pkg::OFF_MODE, 32'h0, r);
    chk(r[12:0] === 13'h0022, "mode reset value");
    ahb(1'b0, sdm_pkg::OFF_STATUS, 32'h0, r);
    chk(r[0] === 1'b0, "ready during wait");
    ahb(1'b0, 8'h40, 32'h0, r);
    chk(r === 32'h0, "unmapped read");
    poll(0, 1'b1);
    chk(mode_valid === 1'b1 && mode === 13'h0022, "init load");
    for (i = 0; i < 10; i++) begin
      b = i < 8 ? i / 2 : 7;
      o = i < 8 ? i % 2 : 0;
      ws = (i % 3 == 1);
      cl = 2 + i % 2;
      m = {3'h0, ws, 2'h0, cl[2:0], o[0], b[2:0]};
      if (i == 9) m = 13'h00a2;
      ahb(1'b1, sdm_pkg::OFF_MODE, {19'h0, m}, r);
      ahb(1'b1, sdm_pkg::OFF_CTRL, 32'h8, r);
      k = 0;
      while (mode !== m && k < 40) begin
        @(posedge hclk);
        k++;
      end
      chk(mode === m, "mode reload");
      s = b == 7 ? 8'hfd : 8'({$random(seed)} % 256);
      rq.delete();
      ahb(1'b1, sdm_pkg::OFF_COLUMN, {24'h0, s}, r);
      ahb(1'b1, sdm_pkg::OFF_CTRL, 32'h1, r);
      if (i == 9) begin
        repeat (15) @(posedge hclk);
        chk(rq.size() == 0, "test mode read");
      end else begin
        wait_n(1'b0, b == 7 ? 6 : 1 << b);
        if (b == 7) ahb(1'b1, sdm_pkg::OFF_CTRL, 32'h4, r);
        poll(1, 1'b0);
        ahb(1'b0, sdm_pkg::OFF_RDDATA, 32'h0, r);
        chk(r === {24'hc35a96, s}, "first read word");
        n = rq.size();
        repeat (5) @(posedge hclk);
        chk(rq.size() == n && (b == 7 || n == 1 << b), "beats");
        for (j = 0; j < n; j++)
          chk(rq[j] === 8'(ecol(s, j, b, o)), "read order");
        // Fourth page beat lies past the last column
        if (b == 7) pg = rq[3];
      end
      if (b != 7 && i != 9) begin
        d = $random(seed);
        wq.delete();
        wd.delete();
        ahb(1'b1, sdm_pkg::OFF_WRDATA, d, r);
        ahb(1'b1, sdm_pkg::OFF_CTRL, 32'h2, r);
        n = ws ? 1 : 1 << b;
        wait_n(1'b1, n);
        repeat (4) @(posedge hclk);
        chk(wq.size() == n, "write beats");
        for (j = 0; j < n; j++)
          chk(wq[j] === 8'(ecol(s, j, b, o)) && wd[j] === d, "w");
      end
    end
    chk(pg === 8'h00, "page wrap kept");
    chk(hresp === 1'b0, "bus response");
    conclude();
  end
endmodule : sdram_init_mode_burst_bench

// ===== test/sdm_link_chk.sv
module sdm_link_chk #(
  parameter int PWR_WAIT_CYC = sdm_pkg::PWR_WAIT_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link
  input wire logic [3:0] cmd,
  input wire logic [12:0] addr,
  input wire logic dq_ctl_oe_n,
  input wire logic dq_dev_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  int cyc;
  int refs;
  int run;
  int wbeats;
  logic pre_seen;
  logic loaded;
  logic [12:0] mw;
  logic idle;
  // Page and reserved lengths are judged here as one write beat
  assign wbeats = (mw[9] || mw[2]) ? 1 : (1 << mw[1:0]);
  assign idle = (cmd == sdm_pkg::CMD_NOP) || (cmd == sdm_pkg::CMD_INHIBIT);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc <= 0;
      refs <= 0;
      run <= 0;
      pre_seen <= 1'b0;
      loaded <= 1'b0;
      mw <= 13'h0000;
    end else begin
      cyc <= (cyc < 100000) ? cyc + 1 : cyc;
      run <= !dq_ctl_oe_n ? run + 1 : 0;
      if (cmd == sdm_pkg::CMD_PRECHARGE) pre_seen <= 1'b1;
      if (cmd == sdm_pkg::CMD_REFRESH) refs <= refs + 1;
      if (cmd == sdm_pkg::CMD_LOAD_MODE) begin
        loaded <= 1'b1;
        mw <= addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_wait_quiet: assert property (
    cyc < PWR_WAIT_CYC |-> idle)
    else $error("command during power-up wait");
  a_first_pre: assert property (
    !pre_seen && !idle |->
      cmd == sdm_pkg::CMD_PRECHARGE && addr[sdm_pkg::PRE_ALL_BIT])
    else $error("first command is not precharge all");
  a_ref_after_pre: assert property (
    cmd == sdm_pkg::CMD_REFRESH |-> pre_seen)
    else $error("refresh before precharge");
  a_two_refresh: assert property (
    cmd == sdm_pkg::CMD_LOAD_MODE |-> refs >= 2)
    else $error("mode load before two refreshes");
  a_load_first: assert property (
    cmd == sdm_pkg::CMD_READ || cmd == sdm_pkg::CMD_WRITE |-> loaded)
    else $error("access before mode load");
  a_load_settle: assert property (
    cmd == sdm_pkg::CMD_LOAD_MODE |=> (cmd == sdm_pkg::CMD_NOP) [*2])
    else $error("no settle gap after mode load");
  a_rd_quiet: assert property (
    cmd == sdm_pkg::CMD_READ && dq_dev_oe_n |=> dq_dev_oe_n)
    else $error("read data driven too early");
  a_rd_lat_two: assert property (
    cmd == sdm_pkg::CMD_READ && mw[8:4] == 5'h02 |-> ##2 !dq_dev_oe_n)
    else $error("latency two data missing");
  a_rd_lat_three: assert property (
    cmd == sdm_pkg::CMD_READ && mw[8:4] == 5'h03 |->
      ##2 dq_dev_oe_n ##1 !dq_dev_oe_n)
    else $error("latency three data misplaced");
  a_wr_beats: assert property (
    dq_ctl_oe_n && run > 0 |-> run == wbeats)
    else $error("write drive length wrong");
endmodule : sdm_link_chk
